// ### hdl/epv_pkg.sv
// Constants shared by both ends of the program and verify port of a
// 1K x 8 on-chip program memory. Assumes one 125 MHz clock, mclk.
`default_nettype none

package epv_pkg;

   // ------------------------------------------------------------------
   // Widths and sizes
   // ------------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int UPPER_W = 2;
   localparam int MEM_WORDS = 1024;
   localparam int CNT_W = 24;

   // ------------------------------------------------------------------
   // Timing, in their own units and in mclk cycles
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int TCY_NS = 5000;
   // Least time: round up to whole clocks
   localparam int TCY_CLKS = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_TCY = 4;
   localparam int SETUP_CLKS = SETUP_TCY * TCY_CLKS;
   localparam int PULSE_MS = 50;
   localparam int PULSE_CLKS = (PULSE_MS * 1000000) / CLK_PERIOD_NS;
   localparam int ALE_HALF_CLKS = TCY_CLKS / 2;
   localparam int ALE_TIMEOUT_CLKS = 2 * TCY_CLKS;

   // ------------------------------------------------------------------
   // Reset values of the programmer's pins (idle socket conditions)
   // ------------------------------------------------------------------
   localparam logic MODE_SEL_RST = 1'b1;
   localparam logic PGM_EN_RST = 1'b0;
   localparam logic RST_PIN_RST = 1'b0;
   localparam logic STROBE_RST = 1'b0;
   localparam logic VDD_HI_RST = 1'b0;
   localparam logic [DATA_W-1:0] BUS_RST = 8'h00;

endpackage : epv_pkg

`default_nettype wire

// ### hdl/epv_link_if.sv
// Pins between the programmer and the device socket.
// Assumes both ends share mclk; the bus level is resolved here.
`default_nettype none

interface epv_link_if;

   // ------------------------------------------------------------------
   // Pins driven by the programmer
   // ------------------------------------------------------------------
   logic mode_sel;
   logic program_enable_input;
   logic rst_pin;
   logic write_strobe_pulse;
   logic vdd_high;
   logic [epv_pkg::UPPER_W-1:0] upper_address_lines;
   logic [epv_pkg::DATA_W-1:0] bus_p_out;
   logic bus_p_oe;

   // ------------------------------------------------------------------
   // Pins driven by the device
   // ------------------------------------------------------------------
   logic [epv_pkg::DATA_W-1:0] bus_d_out;
   logic bus_d_oe;
   logic ale;

   // Wire level of the shared bus; a floating bus reads as pulled high
   logic [epv_pkg::DATA_W-1:0] bus;
   assign bus = bus_d_oe ? bus_d_out : (bus_p_oe ? bus_p_out : 8'hFF);

   modport dev (
      input mode_sel, program_enable_input, rst_pin, write_strobe_pulse,
      input vdd_high, upper_address_lines, bus,
      output bus_d_out, bus_d_oe, ale
   );

   modport host (
      output mode_sel, program_enable_input, rst_pin, write_strobe_pulse,
      output vdd_high, upper_address_lines, bus_p_out, bus_p_oe,
      input bus, ale
   );

endinterface : epv_link_if

`default_nettype wire

// ### hdl/epv_device.sv
// Device end: program memory with its program and verify port.
// Assumes pins are synchronous to mclk and the programmer keeps timing.
`default_nettype none

module epv_device (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   // Socket pins
   epv_link_if.dev link,
   // Fetch port for the core
   input wire logic [epv_pkg::ADDR_W-1:0] fetch_addr,
   output logic [epv_pkg::DATA_W-1:0] fetch_data,
   output logic pgm_active
);

   // ------------------------------------------------------------------
   // Storage and state
   // ------------------------------------------------------------------
   logic [epv_pkg::DATA_W-1:0] mem [epv_pkg::MEM_WORDS];
   logic [epv_pkg::ADDR_W-1:0] addr_reg;
   logic rst_pin_d_reg;
   logic [epv_pkg::DATA_W-1:0] bus_out_reg;
   logic bus_oe_reg;
   logic [epv_pkg::CNT_W-1:0] ale_cnt_reg;
   logic ale_reg;
   logic rst_rise;
   logic verify_mode;

   assign rst_rise = link.rst_pin & ~rst_pin_d_reg;
   // Mode low programs, high verifies, under enable
   assign verify_mode = link.program_enable_input & link.mode_sel
      & link.rst_pin;

   // Reset pin edge detector
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_pin_d_reg <= 1'b0;
      end else if (ce) begin
         rst_pin_d_reg <= link.rst_pin;
      end
   end

   // Address latch on reset rise, only with enable up
   // Upper lines over bus form the word address
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         addr_reg <= '0;
      end else if (ce && rst_rise && link.program_enable_input) begin
         addr_reg <= {link.upper_address_lines, link.bus};
      end
   end

   // Write only while the pulse is high with power applied
   // No reset on the array: a memory keeps its contents
   always_ff @(posedge mclk) begin
      if (ce && link.program_enable_input && !link.mode_sel
          && link.rst_pin && link.vdd_high && link.write_strobe_pulse) begin
         mem[addr_reg] <= link.bus;
      end
   end

   // Verify drive: one clock after mode or reset rise, well inside
   // the four cycle limit
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bus_out_reg <= 8'h00;
         bus_oe_reg <= 1'b0;
      end else if (ce) begin
         bus_out_reg <= mem[addr_reg];
         bus_oe_reg <= verify_mode;
      end
   end

   // Core fetch port, registered
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fetch_data <= 8'h00;
      end else if (ce) begin
         fetch_data <= mem[fetch_addr];
      end
   end

   // Address strobe runs once per device cycle, proof of seating
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ale_cnt_reg <= '0;
         ale_reg <= 1'b0;
      end else if (ce) begin
         if (ale_cnt_reg == epv_pkg::CNT_W'(epv_pkg::ALE_HALF_CLKS - 1))
            begin
            ale_cnt_reg <= '0;
            ale_reg <= ~ale_reg;
         end else begin
            ale_cnt_reg <= ale_cnt_reg + 1'b1;
         end
      end
   end

   assign link.bus_d_out = bus_out_reg;
   assign link.bus_d_oe = bus_oe_reg;
   assign link.ale = ale_reg;
   assign pgm_active = link.program_enable_input;

endmodule // epv_device

`default_nettype wire

// ### hdl/epv_programmer.sv
// Programmer end: writes and verifies one word per start request.
// Assumes the device shares mclk and answers on the resolved bus.
`default_nettype none

module epv_programmer #(
   parameter int unsigned PULSE_CLKS = epv_pkg::PULSE_CLKS
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   // Socket pins
   epv_link_if.host link,
   // Request
   input wire logic start,
   input wire logic [epv_pkg::ADDR_W-1:0] addr_in,
   input wire logic [epv_pkg::DATA_W-1:0] data_in,
   // Status
   output logic busy,
   output logic done,
   output logic pass,
   output logic seat_fault
);

   // ------------------------------------------------------------------
   // Sequence states
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE, S_MODE_LOW, S_EN_ON, S_ADDR, S_RST_HI, S_DATA, S_VDD_ON,
      S_PULSE, S_HOLD, S_VERIFY, S_MODE_BACK, S_RST_LOW, S_EN_OFF
   } epv_pgm_state_t;

   epv_pgm_state_t state_reg, state_next;
   logic [epv_pkg::CNT_W-1:0] cnt_reg;
   logic [epv_pkg::CNT_W-1:0] wait_clks;
   logic wait_done;
   logic [epv_pkg::ADDR_W-1:0] addr_reg;
   logic [epv_pkg::DATA_W-1:0] data_reg;
   logic mode_reg, en_reg, rst_reg, strobe_reg, vdd_reg, oe_reg;
   logic [epv_pkg::DATA_W-1:0] bus_reg;
   logic [epv_pkg::UPPER_W-1:0] upper_reg;
   logic mode_next, en_next, rst_next, strobe_next, vdd_next, oe_next;
   logic [epv_pkg::DATA_W-1:0] bus_next;
   logic ale_d_reg;
   logic [epv_pkg::CNT_W-1:0] ale_age_reg;
   logic seated;

   // Every step waits four device cycles, except the long pulse
   always_comb begin
      if (state_reg == S_PULSE) begin
         wait_clks = epv_pkg::CNT_W'(PULSE_CLKS);
      end else begin
         wait_clks = epv_pkg::CNT_W'(epv_pkg::SETUP_CLKS);
      end
   end
   assign wait_done = (cnt_reg == wait_clks - 1'b1);

   // ------------------------------------------------------------------
   // Seating watchdog on the device's address strobe
   // ------------------------------------------------------------------
   // Age since the last strobe edge; too old means a bad socket
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ale_d_reg <= 1'b0;
         ale_age_reg <= '0;
      end else if (ce) begin
         ale_d_reg <= link.ale;
         if (link.ale != ale_d_reg) begin
            ale_age_reg <= '0;
         end else if (!seated) begin
            ale_age_reg <= ale_age_reg;
         end else begin
            ale_age_reg <= ale_age_reg + 1'b1;
         end
      end
   end
   assign seated =
      (ale_age_reg < epv_pkg::CNT_W'(epv_pkg::ALE_TIMEOUT_CLKS));

   // ------------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------------
   // Next step; one word completes before the next is taken
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            // A missing strobe refuses the start
            if (start && seated) begin
               state_next = S_MODE_LOW;
            end
         end
         S_MODE_LOW: if (wait_done) state_next = S_EN_ON;
         S_EN_ON: if (wait_done) state_next = S_ADDR;
         S_ADDR: if (wait_done) state_next = S_RST_HI;
         S_RST_HI: if (wait_done) state_next = S_DATA;
         S_DATA: if (wait_done) state_next = S_VDD_ON;
         S_VDD_ON: if (wait_done) state_next = S_PULSE;
         S_PULSE: if (wait_done) state_next = S_HOLD;
         S_HOLD: if (wait_done) state_next = S_VERIFY;
         S_VERIFY: if (wait_done) state_next = S_MODE_BACK;
         S_MODE_BACK: if (wait_done) state_next = S_RST_LOW;
         S_RST_LOW: if (wait_done) state_next = S_EN_OFF;
         S_EN_OFF: if (wait_done) state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
   end

   // Pin levels that each step holds
   always_comb begin
      mode_next = 1'b0;
      en_next = 1'b1;
      rst_next = 1'b1;
      strobe_next = 1'b0;
      vdd_next = 1'b0;
      oe_next = 1'b1;
      bus_next = data_reg;
      case (state_next)
         S_IDLE: begin
            // Socket conditions: reset low, mode high, bus floats
            mode_next = epv_pkg::MODE_SEL_RST;
            en_next = epv_pkg::PGM_EN_RST;
            rst_next = epv_pkg::RST_PIN_RST;
            oe_next = 1'b0;
            bus_next = epv_pkg::BUS_RST;
         end
         S_MODE_LOW: begin
            // Mode low first, enable still off
            en_next = 1'b0;
            rst_next = 1'b0;
            oe_next = 1'b0;
         end
         S_EN_ON: begin
            // Enable raised only once mode is low
            rst_next = 1'b0;
            oe_next = 1'b0;
         end
         S_ADDR: begin
            // Low address byte on the bus
            rst_next = 1'b0;
            bus_next = addr_reg[epv_pkg::DATA_W-1:0];
         end
         S_RST_HI: begin
            // Address held through reset rise
            bus_next = addr_reg[epv_pkg::DATA_W-1:0];
         end
         S_DATA: begin
            // Data replaces the address
         end
         S_VDD_ON: begin
            vdd_next = 1'b1;
         end
         S_PULSE: begin
            // Exactly one pulse under programming power
            vdd_next = 1'b1;
            strobe_next = 1'b1;
         end
         S_HOLD: begin
            // Data kept after the pulse, power back to normal
         end
         S_VERIFY: begin
            // Release the bus, mode high reads back
            mode_next = 1'b1;
            oe_next = 1'b0;
         end
         S_MODE_BACK: begin
            // Mode low before reset low
            oe_next = 1'b0;
         end
         S_RST_LOW: begin
            rst_next = 1'b0;
            oe_next = 1'b0;
         end
         S_EN_OFF: begin
            // Mode held low after program mode ends
            en_next = 1'b0;
            rst_next = 1'b0;
            oe_next = 1'b0;
         end
         default: begin
            oe_next = 1'b0;
         end
      endcase
   end

   // State and step counter
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= S_IDLE;
         cnt_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
         if (state_next != state_reg) begin
            cnt_reg <= '0;
         end else if (state_reg != S_IDLE) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   // Request capture; held for the whole word
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         addr_reg <= '0;
         data_reg <= 8'h00;
      end else if (ce && state_reg == S_IDLE && start && seated) begin
         addr_reg <= addr_in;
         data_reg <= data_in;
      end
   end

   // Registered pin drivers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mode_reg <= epv_pkg::MODE_SEL_RST;
         en_reg <= epv_pkg::PGM_EN_RST;
         rst_reg <= epv_pkg::RST_PIN_RST;
         strobe_reg <= epv_pkg::STROBE_RST;
         vdd_reg <= epv_pkg::VDD_HI_RST;
         oe_reg <= 1'b0;
         bus_reg <= epv_pkg::BUS_RST;
         upper_reg <= '0;
      end else if (ce) begin
         mode_reg <= mode_next;
         en_reg <= en_next;
         rst_reg <= rst_next;
         strobe_reg <= strobe_next;
         vdd_reg <= vdd_next;
         oe_reg <= oe_next;
         bus_reg <= bus_next;
         upper_reg <= addr_reg[epv_pkg::ADDR_W-1:epv_pkg::DATA_W];
      end
   end

   // Status: sample read-back at the end of the verify wait
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         done <= 1'b0;
         pass <= 1'b0;
         seat_fault <= 1'b0;
      end else if (ce) begin
         done <= (state_reg == S_EN_OFF) && wait_done;
         seat_fault <= ~seated;
         if (state_reg == S_VERIFY && wait_done) begin
            pass <= (link.bus == data_reg);
         end
      end
   end

   assign busy = (state_reg != S_IDLE);
   assign link.mode_sel = mode_reg;
   assign link.program_enable_input = en_reg;
   assign link.rst_pin = rst_reg;
   assign link.write_strobe_pulse = strobe_reg;
   assign link.vdd_high = vdd_reg;
   assign link.bus_p_out = bus_reg;
   assign link.bus_p_oe = oe_reg;
   assign link.upper_address_lines = upper_reg;

endmodule // epv_programmer

`default_nettype wire

// ### testbench/epv_link_props.sv
// Concurrent checks on the pins between programmer and device.
// Assumes one clock, mclk, and the resolved bus of the link interface.
`default_nettype none

module epv_link_props #(
   parameter int unsigned PULSE_CLKS = 40
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Programmer pins
   input wire logic mode_sel,
   input wire logic program_enable_input,
   input wire logic rst_pin,
   input wire logic write_strobe_pulse,
   input wire logic vdd_high,
   input wire logic [epv_pkg::UPPER_W-1:0] upper_address_lines,
   input wire logic [epv_pkg::DATA_W-1:0] bus_p_out,
   input wire logic bus_p_oe,
   // Device pins and resolved bus
   input wire logic [epv_pkg::DATA_W-1:0] bus_d_out,
   input wire logic bus_d_oe,
   input wire logic ale,
   input wire logic [epv_pkg::DATA_W-1:0] bus
);
   // Ages lag the pins by one sample, hence the minus one
   localparam int SETUP = epv_pkg::SETUP_CLKS - 1;
   localparam int PULSE_AGE = PULSE_CLKS - 1;
   localparam int TCY = epv_pkg::TCY_CLKS;

   // ------------------------------------------------------------------
   // Stable-time counters
   // ------------------------------------------------------------------
   logic mode_q, rst_q, stb_q, ale_q;
   logic [10:0] bus_q;
   logic [23:0] mode_age, rst_age, bus_age, stb_age, ale_age;

   function automatic logic [23:0] bump(input logic [23:0] a);
      return (&a) ? a : a + 24'h1;
   endfunction

   // Last sample of each watched pin, seeded with the idle levels
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         {mode_q, rst_q, stb_q, ale_q} <= 4'h8;
         bus_q <= 11'h000;
      end else begin
         {mode_q, rst_q, stb_q, ale_q} <=
            {mode_sel, rst_pin, write_strobe_pulse, ale};
         bus_q <= {bus_p_oe, bus_p_out, upper_address_lines};
      end
   end

   // Cycles since a pin last moved; saturates so long idles never wrap
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mode_age <= 24'h0;
         rst_age <= 24'h0;
         bus_age <= 24'h0;
         stb_age <= 24'h0;
         ale_age <= 24'h0;
      end else begin
         mode_age <= (mode_sel != mode_q) ? 24'h0 : bump(mode_age);
         rst_age <= (rst_pin != rst_q) ? 24'h0 : bump(rst_age);
         bus_age <= ({bus_p_oe, bus_p_out, upper_address_lines} != bus_q) ?
            24'h0 : bump(bus_age);
         stb_age <= (write_strobe_pulse != stb_q) ? 24'h0 : bump(stb_age);
         ale_age <= (ale != ale_q) ? 24'h0 : bump(ale_age);
      end
   end

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_enable_rise;
      $rose(program_enable_input);
   endsequence

   sequence s_verify_enter;
      program_enable_input && rst_pin && $rose(mode_sel);
   endsequence

   a_mode_before_enable: assert property (
      s_enable_rise |-> !mode_sel && mode_age >= SETUP)
      else $error("Enable rose without settled program mode");
   a_reset_before_enable: assert property (
      s_enable_rise |-> !rst_pin && rst_age >= SETUP)
      else $error("Reset not settled before enable");
   a_addr_setup: assert property (
      $rose(rst_pin) |-> program_enable_input && bus_p_oe && !bus_d_oe &&
         bus_age >= SETUP)
      else $error("Address not settled at latch");
   a_addr_hold: assert property (
      $changed({bus_p_out, upper_address_lines}) && rst_pin |->
         rst_age >= SETUP)
      else $error("Address changed too soon after latch");
   a_reset_width: assert property (
      $fell(rst_pin) |-> !mode_sel && rst_age >= SETUP)
      else $error("Latch pulse too short or out of order");
   a_data_setup: assert property (
      $rose(write_strobe_pulse) |-> vdd_high && bus_p_oe &&
         bus_age >= SETUP)
      else $error("Write data not settled before pulse");
   a_pulse_width: assert property (
      $fell(write_strobe_pulse) |-> stb_age == PULSE_AGE && !vdd_high)
      else $error("Write pulse width wrong or power left on");
   // Only a driven bus can break the hold; a floating one is unseen
   a_data_hold: assert property (
      $changed({bus_p_oe, bus_p_out}) && $past(bus_p_oe) |->
         !write_strobe_pulse && stb_age >= SETUP)
      else $error("Write data released too early");
   a_strobe_qualified: assert property (
      write_strobe_pulse |-> vdd_high && rst_pin && program_enable_input &&
         !mode_sel)
      else $error("Write pulse outside program mode");
   a_verify_order: assert property (
      s_verify_enter |-> !write_strobe_pulse && !vdd_high &&
         rst_age >= SETUP && stb_age >= SETUP)
      else $error("Verify entered out of order");
   a_verify_drive: assert property (
      s_verify_enter |-> ##1 (bus_d_oe && !bus_p_oe && bus == bus_d_out) [*8])
      else $error("Device did not drive read-back");
   a_verify_only: assert property (
      bus_d_oe |-> $past(program_enable_input && mode_sel && rst_pin))
      else $error("Device drove bus outside verify");
   a_ale_running: assert property (
      ale_age < TCY)
      else $error("Address strobe stopped toggling");
endmodule : epv_link_props

`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench: programmer and device joined by the link.
// Assumes the package, interface and both design ends compile first.
`default_nettype none

`define EPV_CHECK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // Short pulse keeps three whole words inside the run budget
   localparam int unsigned PULSE = 40;

   logic mclk, resetn, ce, start, busy, done, pass, seat_fault, pgm_active;
   logic [epv_pkg::ADDR_W-1:0] addr_in, fetch_addr, cur_addr;
   logic [epv_pkg::DATA_W-1:0] data_in, fetch_data, cur_data;
   logic rst_prev, stb_prev, doe_prev;
   logic [31:0] lfsr;
   logic [7:0] model_mem [int];
   int miscompares, check_count;

   // ------------------------------------------------------------------
   // Both ends and the link checker
   // ------------------------------------------------------------------
   epv_link_if link ();

   epv_device u_epv_device (
      .mclk(mclk), .resetn(resetn), .ce(ce), .link(link),
      .fetch_addr(fetch_addr), .fetch_data(fetch_data),
      .pgm_active(pgm_active)
   );

   epv_programmer #(.PULSE_CLKS(PULSE)) u_epv_programmer (
      .mclk(mclk), .resetn(resetn), .ce(ce), .link(link),
      .start(start), .addr_in(addr_in), .data_in(data_in),
      .busy(busy), .done(done), .pass(pass), .seat_fault(seat_fault)
   );

   epv_link_props #(.PULSE_CLKS(PULSE)) u_epv_link_props (
      .mclk(mclk), .resetn(resetn),
      .mode_sel(link.mode_sel),
      .program_enable_input(link.program_enable_input),
      .rst_pin(link.rst_pin),
      .write_strobe_pulse(link.write_strobe_pulse),
      .vdd_high(link.vdd_high),
      .upper_address_lines(link.upper_address_lines),
      .bus_p_out(link.bus_p_out), .bus_p_oe(link.bus_p_oe),
      .bus_d_out(link.bus_d_out), .bus_d_oe(link.bus_d_oe),
      .ale(link.ale), .bus(link.bus)
   );

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One whole word; poke fires a stray request while the word runs
   task automatic program_word(input logic [9:0] a, input logic [7:0] d,
                               input bit poke);
      int n;
      int want;
      want = 11 * epv_pkg::SETUP_CLKS + PULSE;
      cur_addr = a;
      cur_data = d;
      addr_in = a;
      data_in = d;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      `EPV_CHECK(busy, 1'b1)
      n = 0;
      if (poke) begin
         repeat (100) @(negedge mclk);
         addr_in = ~a;
         data_in = ~d;
         start = 1'b1;
         @(negedge mclk);
         start = 1'b0;
         // A frozen enable must stretch the word by exactly its length
         ce = 1'b0;
         repeat (50) @(negedge mclk);
         ce = 1'b1;
         n = 151;
         want = want + 50;
      end
      while (done !== 1'b1 && n < 40000) begin
         @(negedge mclk);
         n++;
      end
      model_mem[a] = d;
      `EPV_CHECK(n, want)
      `EPV_CHECK({done, pass}, 2'h3)
      @(negedge mclk);
      `EPV_CHECK({done, busy}, 2'h0)
      `EPV_CHECK(pgm_active, 1'b0)
   endtask

   // ------------------------------------------------------------------
   // Clock, watchdog, wire monitor
   // ------------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Three words take about 83k clocks; beyond this the run has hung
   initial begin
      repeat (98000) @(posedge mclk);
      miscompares++;
      conclude();
   end

   // Settled view of the wire: latched address, write data, read-back
   always @(negedge mclk) begin
      if (resetn && link.rst_pin && !rst_prev) begin
         `EPV_CHECK({link.upper_address_lines, link.bus}, cur_addr)
         `EPV_CHECK(pgm_active, 1'b1)
      end
      if (resetn && link.write_strobe_pulse && !stb_prev)
         `EPV_CHECK(link.bus, cur_data)
      if (resetn && link.bus_d_oe && !doe_prev)
         `EPV_CHECK(link.bus, cur_data)
      rst_prev = link.rst_pin;
      stb_prev = link.write_strobe_pulse;
      doe_prev = link.bus_d_oe;
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      start = 1'b0;
      addr_in = 10'h000;
      data_in = 8'h00;
      fetch_addr = 10'h000;
      cur_addr = 10'h000;
      cur_data = 8'h00;
      lfsr = 32'h5D69FAB1;
      repeat (20) @(negedge mclk);
      resetn = 1'b1;
      `EPV_CHECK({link.mode_sel, link.rst_pin, link.bus_p_oe}, 3'h4)
      `EPV_CHECK(link.write_strobe_pulse, 1'b0)
      `EPV_CHECK(seat_fault, 1'b0)
      lfsr = lfsr_next(lfsr);
      program_word(10'h000, lfsr[7:0], 1'b0);
      lfsr = lfsr_next(lfsr);
      program_word(10'h3FF, lfsr[7:0], 1'b1);
      lfsr = lfsr_next(lfsr);
      program_word(lfsr[9:0], lfsr[17:10], 1'b0);
      // Every word written must read back through the fetch port
      foreach (model_mem[k]) begin
         fetch_addr = k[9:0];
         @(negedge mclk);
         `EPV_CHECK(fetch_data, model_mem[k])
      end
      conclude();
   end
endmodule : tb_top

`default_nettype wire
